// ### rtl/fiml_defs.svh
// Register offsets, reset values, field positions and write masks for the
// fault interrupt mask and latch block.
// Assumes an 8-bit register space addressed by the device's control port.
`ifndef FIML_DEFS_SVH
`define FIML_DEFS_SVH

// ==========================================================================
// Offsets
`define FIML_OFS_MASK_PROT   8'h3b
`define FIML_OFS_MASK_CRC    8'h3c
`define FIML_OFS_MASK_CLK    8'h3d
`define FIML_OFS_MASK_TEMP   8'h40
`define FIML_OFS_MASK_THERM  8'h41
`define FIML_OFS_FLAG_PROT   8'h42
`define FIML_OFS_FLAG_CRC    8'h43

// ==========================================================================
// Reset values (reserved bits hold their printed values)
`define FIML_RST_MASK_PROT   8'hfc
`define FIML_RST_MASK_CRC    8'hbb
`define FIML_RST_MASK_CLK    8'hdd
`define FIML_RST_MASK_TEMP   8'hf6
`define FIML_RST_MASK_THERM  8'h14
`define FIML_RST_FLAG        8'h00

// ==========================================================================
// Software-writable bits of each mask register
`define FIML_WR_MASK_PROT    8'hff
`define FIML_WR_MASK_CRC     8'h41
`define FIML_WR_MASK_CLK     8'h80
`define FIML_WR_MASK_TEMP    8'hf9
`define FIML_WR_MASK_THERM   8'hfc

// ==========================================================================
// Field positions in the second flag register and its maskable bits
`define FIML_BIT_FUSE_CRC    6
`define FIML_BIT_NOISE_GATE  2
`define FIML_BIT_GAIN_LIM    0
`define FIML_IRQ2_BITS       8'h41
// Flags of the first register that force shutdown: frame clock, OC, OT
`define FIML_SHDN1_BITS      8'h07

`endif

// ### rtl/fiml_pkg.sv
// Types shared by the fault interrupt mask and latch block.
// Assumes fiml_defs.svh supplies all numeric constants.
package fiml_pkg;

    // ======================================================================
    // Event inputs, one-cycle or level, from the protection logic
    typedef struct packed {
        logic drop_mute;
        logic drop_infinite_hold;
        logic limiter_max_atten;
        logic high_supply_below_inflection;
        logic limiter_active;
        logic frame_clock_error;
        logic overcurrent;
        logic overtemp;
        logic fuse_crc_error;
        logic noise_gate_active;
        logic gain_limiter;
    } fiml_evt_type;

    // ======================================================================
    // Register access from the control port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fiml_req_type;

    // ======================================================================
    // Mask register contents handed to the rest of the device
    typedef struct packed {
        logic [7:0] prot;
        logic [7:0] crc_lim;
        logic [7:0] clk;
        logic [7:0] temp_supply;
        logic [7:0] therm_drop;
    } fiml_masks_type;

endpackage : fiml_pkg

// ### rtl/fiml_flag_latch.sv
// Sticky flag register: bits set on events and clear only on a clear strobe.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps
module fiml_flag_latch #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set_in,
    input  wire logic         clr,
    output logic      [W-1:0] flags_r
);
    logic [W-1:0] flags_nxt;

    // An event in the clearing cycle survives the clear
    always_comb begin
        flags_nxt = clr ? set_in : (flags_r | set_in);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

endmodule : fiml_flag_latch

// ### rtl/fiml_top.sv
// Fault and event interrupt masks, latched flags, interrupt and shutdown.
// Assumes events and register requests arrive on clk from device logic,
// and that flag_clear is the device's clear-latched-flags strobe.
//
// Functional notes
// - Mask one hides event, zero reports it
// - Protection mask resets fch, OC/OT unmasked
// - CRC/limiter mask resets bbh, reserved read-only
// - Clock mask resets ddh, bit7 only writable
// - Temperature/supply mask resets f6h
// - Thermal/drop mask resets 14h
// - First flag register read-only, resets zero
// - Frame clock, OC, OT flags force shutdown
// - Fuse CRC flag in bit6 forces shutdown
// - Bit2 reports noise gate detected
// - Bit0 gain limiter; reserved bits read zero
`timescale 1ns/100ps
`include "fiml_defs.svh"
module fiml_top (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire fiml_pkg::fiml_evt_type  evt,
    input  wire fiml_pkg::fiml_req_type  req,
    input  wire logic                    flag_clear,
    output logic [7:0]                   rdata_r,
    output logic                         irq_r,
    output logic                         shutdown_r,
    output fiml_pkg::fiml_masks_type     masks_r
);
    import fiml_pkg::*;

    // ======================================================================
    // Mask registers
    fiml_masks_type masks_nxt;

    function automatic logic [7:0] fiml_merge(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] wmask);
        fiml_merge = (new_v & wmask) | (old_v & ~wmask);
    endfunction : fiml_merge

    // Reserved bits never change, so they keep their reset values
    always_comb begin
        masks_nxt = masks_r;
        if (req.wr) begin
            unique case (req.addr)
                `FIML_OFS_MASK_PROT: begin
                    masks_nxt.prot = fiml_merge(masks_r.prot, req.wdata,
                                                `FIML_WR_MASK_PROT);
                end
                `FIML_OFS_MASK_CRC: begin
                    masks_nxt.crc_lim = fiml_merge(masks_r.crc_lim, req.wdata,
                                                   `FIML_WR_MASK_CRC);
                end
                `FIML_OFS_MASK_CLK: begin
                    masks_nxt.clk = fiml_merge(masks_r.clk, req.wdata,
                                               `FIML_WR_MASK_CLK);
                end
                `FIML_OFS_MASK_TEMP: begin
                    masks_nxt.temp_supply = fiml_merge(masks_r.temp_supply, req.wdata,
                                                       `FIML_WR_MASK_TEMP);
                end
                `FIML_OFS_MASK_THERM: begin
                    masks_nxt.therm_drop = fiml_merge(masks_r.therm_drop, req.wdata,
                                                      `FIML_WR_MASK_THERM);
                end
                default: begin
                    masks_nxt = masks_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            masks_r.prot        <= `FIML_RST_MASK_PROT;
            masks_r.crc_lim     <= `FIML_RST_MASK_CRC;
            masks_r.clk         <= `FIML_RST_MASK_CLK;
            masks_r.temp_supply <= `FIML_RST_MASK_TEMP;
            masks_r.therm_drop  <= `FIML_RST_MASK_THERM;
        end else begin
            masks_r <= masks_nxt;
        end
    end

    // ======================================================================
    // Latched flags
    logic [7:0] set_prot;
    logic [7:0] set_crc;
    logic [7:0] flags_prot_r;
    logic [7:0] flags_crc_r;

    always_comb begin
        set_prot = {evt.drop_mute, evt.drop_infinite_hold, evt.limiter_max_atten,
                    evt.high_supply_below_inflection, evt.limiter_active,
                    evt.frame_clock_error, evt.overcurrent, evt.overtemp};
        set_crc = 8'h00;
        set_crc[`FIML_BIT_FUSE_CRC]   = evt.fuse_crc_error;
        set_crc[`FIML_BIT_NOISE_GATE] = evt.noise_gate_active;
        set_crc[`FIML_BIT_GAIN_LIM]   = evt.gain_limiter;
    end

    // Flags hold after the event is gone until the clear strobe
    fiml_flag_latch #(.W(8)) u_flags_prot (
        .clk     (clk),
        .rst     (rst),
        .set_in  (set_prot),
        .clr     (flag_clear),
        .flags_r (flags_prot_r)
    );

    fiml_flag_latch #(.W(8)) u_flags_crc (
        .clk     (clk),
        .rst     (rst),
        .set_in  (set_crc),
        .clr     (flag_clear),
        .flags_r (flags_crc_r)
    );

    // ======================================================================
    // Interrupt, shutdown and read data
    logic       irq_nxt;
    logic       shutdown_nxt;
    logic [7:0] rdata_nxt;

    always_comb begin
        // Noise gate has no mask bit, so it is status only and never interrupts
        irq_nxt = |(flags_prot_r & ~masks_r.prot)
                | |(flags_crc_r & ~masks_r.crc_lim & `FIML_IRQ2_BITS);
        shutdown_nxt = |(flags_prot_r & `FIML_SHDN1_BITS)
                     | flags_crc_r[`FIML_BIT_FUSE_CRC];
        rdata_nxt = rdata_r;
        if (req.rd) begin
            unique case (req.addr)
                `FIML_OFS_MASK_PROT:  rdata_nxt = masks_r.prot;
                `FIML_OFS_MASK_CRC:   rdata_nxt = masks_r.crc_lim;
                `FIML_OFS_MASK_CLK:   rdata_nxt = masks_r.clk;
                `FIML_OFS_MASK_TEMP:  rdata_nxt = masks_r.temp_supply;
                `FIML_OFS_MASK_THERM: rdata_nxt = masks_r.therm_drop;
                `FIML_OFS_FLAG_PROT:  rdata_nxt = flags_prot_r;
                `FIML_OFS_FLAG_CRC:   rdata_nxt = flags_crc_r;
                default:              rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r      <= 1'b0;
            shutdown_r <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            irq_r      <= irq_nxt;
            shutdown_r <= shutdown_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_mask_hides;
        ((flags_prot_r & ~masks_r.prot) == 8'h00 && flags_crc_r == 8'h00) |=> !irq_r;
    endproperty
    a_mask_hides: assert property (p_mask_hides)
        else $error("masked flag raised irq");

    property p_prot_write;
        (req.wr && req.addr == `FIML_OFS_MASK_PROT) |=> (masks_r.prot == $past(req.wdata));
    endproperty
    a_prot_write: assert property (p_prot_write)
        else $error("protection mask write lost");

    property p_crc_reserved;
        (req.rd && req.addr == `FIML_OFS_MASK_CRC) |=> ((rdata_r & 8'hbe) == 8'hba);
    endproperty
    a_crc_reserved: assert property (p_crc_reserved)
        else $error("crc mask reserved bits wrong");

    property p_clk_reserved;
        (req.rd && req.addr == `FIML_OFS_MASK_CLK) |=> (rdata_r[6:0] == 7'h5d);
    endproperty
    a_clk_reserved: assert property (p_clk_reserved)
        else $error("clock mask reserved bits wrong");

    property p_temp_reserved;
        (req.rd && req.addr == `FIML_OFS_MASK_TEMP) |=> (rdata_r[2:1] == 2'b11);
    endproperty
    a_temp_reserved: assert property (p_temp_reserved)
        else $error("temp mask reserved bits wrong");

    property p_therm_reserved;
        (req.rd && req.addr == `FIML_OFS_MASK_THERM) |=> (rdata_r[1:0] == 2'b00);
    endproperty
    a_therm_reserved: assert property (p_therm_reserved)
        else $error("thermal mask low bits set");

    property p_oc_latch;
        evt.overcurrent |=> flags_prot_r[1];
    endproperty
    a_oc_latch: assert property (p_oc_latch)
        else $error("over-current flag not latched");

    property p_fault_shutdown;
        evt.overtemp |=> ##1 shutdown_r;
    endproperty
    a_fault_shutdown: assert property (p_fault_shutdown)
        else $error("no shutdown on over-temp");

    property p_crc_shutdown;
        flags_crc_r[6] |=> shutdown_r;
    endproperty
    a_crc_shutdown: assert property (p_crc_shutdown)
        else $error("no shutdown on crc flag");

    property p_noise_gate;
        evt.noise_gate_active |=> flags_crc_r[`FIML_BIT_NOISE_GATE];
    endproperty
    a_noise_gate: assert property (p_noise_gate)
        else $error("noise gate flag not latched");

    property p_flag2_reserved;
        (req.rd && req.addr == `FIML_OFS_FLAG_CRC) |=> ((rdata_r & 8'hba) == 8'h00);
    endproperty
    a_flag2_reserved: assert property (p_flag2_reserved)
        else $error("reserved flag bits set");

    property p_irq_unmasked;
        (|(flags_prot_r & ~masks_r.prot)) |=> irq_r;
    endproperty
    a_irq_unmasked: assert property (p_irq_unmasked)
        else $error("unmasked flag gave no irq");

    property p_flag_sticks;
        (flags_prot_r[0] && !flag_clear) |=> flags_prot_r[0];
    endproperty
    a_flag_sticks: assert property (p_flag_sticks)
        else $error("latched flag dropped");

endmodule : fiml_top

// ### testbench/tb.sv
// Self-checking bench for the fault interrupt mask and latch block.
// Assumes fiml_pkg and fiml_defs.svh are compiled first; inputs change on falling edges.
`timescale 1ns/100ps
`include "fiml_defs.svh"
module tb;
    import fiml_pkg::*;
    logic           clk;
    logic           rst;
    fiml_evt_type   evt;
    fiml_req_type   req;
    logic           flag_clear;
    logic [7:0]     rdata_r;
    logic           irq_r;
    logic           shutdown_r;
    fiml_masks_type masks_r;
    int             mismatches;
    int             checks;
    logic [7:0]     d;
    logic [7:0]     ofs [5] = '{8'h3b, 8'h3c, 8'h3d, 8'h40, 8'h41};
    logic [7:0]     rsv [5] = '{8'hfc, 8'hbb, 8'hdd, 8'hf6, 8'h14};
    logic [7:0]     wmk [5] = '{8'hff, 8'h41, 8'h80, 8'hf9, 8'hfc};

    fiml_top fiml_top_inst (.clk(clk), .rst(rst), .evt(evt), .req(req),
        .flag_clear(flag_clear), .rdata_r(rdata_r), .irq_r(irq_r),
        .shutdown_r(shutdown_r), .masks_r(masks_r));

    // ======================================================================
    // Clock, reset and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200us;
        mismatches++;
        summarize();
    end

    // ======================================================================
    // Access and compare tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : chk1
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk) begin
            req.wr = 1'b1;
            req.addr = a;
            req.wdata = v;
        end
        @(negedge clk) req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk) begin
            req.rd = 1'b1;
            req.addr = a;
        end
        @(negedge clk) req.rd = 1'b0;
        v = rdata_r;
    endtask : rd
    // One-cycle event and clear, then one more cycle for irq and shutdown to follow
    task automatic pulse(input logic [10:0] e, input logic c);
        @(negedge clk) begin
            evt = e;
            flag_clear = c;
        end
        @(negedge clk) begin
            evt = '0;
            flag_clear = 1'b0;
        end
        @(negedge clk);
    endtask : pulse
    task automatic flags(input logic [15:0] exp);
        rd(8'h42, d);
        chk8(d, exp[15:8], "flags 42");
        rd(8'h43, d);
        chk8(d, exp[7:0], "flags 43");
    endtask : flags
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // ======================================================================
    // Tests
    initial begin
        logic [15:0] fx;
        evt = '0;
        req = '0;
        flag_clear = 1'b0;
        rst = 1'b1;
        mismatches = 0;
        checks = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i], d);
            chk8(d, rsv[i], "mask reset");
            chk8(masks_r[39-8*i -: 8], rsv[i], "mask port reset");
        end
        flags(16'h0000);
        chk1(irq_r, 1'b0, "irq reset");
        chk1(shutdown_r, 1'b0, "shutdown reset");
        $display("test reset done");

        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 8'hff);
            rd(ofs[i], d);
            chk8(d, rsv[i] | wmk[i], "mask ones");
            wr(ofs[i], 8'h00);
            rd(ofs[i], d);
            chk8(d, rsv[i] & ~wmk[i], "mask zeros");
            chk8(masks_r[39-8*i -: 8], rsv[i] & ~wmk[i], "mask port");
        end
        wr(8'h42, 8'hff);
        wr(8'h43, 8'hff);
        flags(16'h0000);
        rd(8'h3e, d);
        chk8(d, 8'h00, "unmapped read");
        $display("test access done");

        // Every event alone, with all flag masks open
        for (int k = 0; k < 11; k++) begin
            fx[15:8] = 8'((11'h001 << k) >> 3);
            fx[7:0] = 8'h00;
            fx[6] = (k == 2);
            fx[2] = (k == 1);
            fx[0] = (k == 0);
            pulse(11'h001 << k, 1'b0);
            chk1(irq_r, k != 1, "irq on event");
            chk1(shutdown_r, k >= 2 && k <= 5, "shutdown on event");
            repeat (3) @(negedge clk);
            flags(fx);
            pulse(11'h000, 1'b1);
            chk1(irq_r, 1'b0, "irq after clear");
            chk1(shutdown_r, 1'b0, "shutdown after clear");
            flags(16'h0000);
        end
        $display("test events done");

        wr(8'h3b, 8'hff);
        pulse(11'h010, 1'b0);
        chk1(irq_r, 1'b0, "masked overcurrent");
        chk1(shutdown_r, 1'b1, "masked overcurrent shutdown");
        wr(8'h3b, 8'hfd);
        @(negedge clk);
        chk1(irq_r, 1'b1, "unmasked overcurrent");
        wr(8'h3b, 8'hff);
        @(negedge clk);
        chk1(irq_r, 1'b0, "remasked overcurrent");
        pulse(11'h400, 1'b1);
        flags(16'h8000);
        pulse(11'h000, 1'b1);
        flags(16'h0000);
        $display("test masking done");
        summarize();
    end
endmodule : tb
